/* pin_select_pkg.sv */
package pin_select_pkg;

  // register addresses on the cpu data bus
  localparam logic [15:0] ANALOG_CFG_ADDR = 16'hff22;
  localparam logic [15:0] MOTOR_MODE_ADDR = 16'hff2a;
  localparam logic [15:0] IN_SWITCH_ADDR  = 16'hff2b;

  // values after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions in motor_port_mode_control
  localparam int MOTOR_EN_LSB   = 0;
  localparam int BRIDGE_SEL_LSB = 4;

  // analog_digital_pin_config field
  localparam int             ANALOG_CFG_W       = 4;
  localparam logic [3:0]     ANALOG_ALL_DIGITAL = 4'h8;

  // pin order inside one motor channel
  localparam int PIN_SIN_P = 0;
  localparam int PIN_SIN_N = 1;
  localparam int PIN_COS_P = 2;
  localparam int PIN_COS_N = 3;

  // default sizes
  localparam int NUM_MOTOR_CH    = 4;
  localparam int PINS_PER_CH     = 4;
  localparam int NUM_ANALOG_PINS = 8;
  localparam int NUM_SWITCH      = 8;

  typedef enum logic [1:0] {BUS_IDLE, BUS_STALL, BUS_DONE} bus_state_e;

endpackage

/* motor_channel_mux.sv */
`timescale 1ns/100ps
module motor_channel_mux
  import pin_select_pkg::*;
(
  input  wire logic       motor_channel_enable,
  input  wire logic       bridge_type_select,
  input  wire logic [1:0] motor_direction_bits,
  input  wire logic       pwm,
  input  wire logic [3:0] port_output_latch,
  output logic      [3:0] pin_value,
  output logic      [3:0] pin_owned
);

  // which leg of each pair carries pwm
  wire       sin_neg = motor_direction_bits[1];
  wire       cos_neg = motor_direction_bits[1] ^ motor_direction_bits[0];
  wire [3:0] active;
  wire [3:0] owned_full;
  wire [3:0] owned_half;

  assign active[PIN_SIN_P] = ~sin_neg;
  assign active[PIN_SIN_N] = sin_neg;
  assign active[PIN_COS_P] = ~cos_neg;
  assign active[PIN_COS_N] = cos_neg;

  // (RQ3) full bridge legs
  assign owned_full = 4'hf;
  // (RQ4) half bridge legs
  assign owned_half = active;

  // (RQ2) port mode when disabled
  assign pin_owned = ~motor_channel_enable ? 4'h0 :
                     (bridge_type_select ? owned_half : owned_full);

  // (RQ3) idle legs drive zero
  assign pin_value = (pin_owned & active & {4{pwm}})
                   | (~pin_owned & port_output_latch);

endmodule

/* motor_and_analog_pin_select.sv */
// Notes on behaviour
// (RQ1) reset clears motor mode and analog/digital config registers to zero
// (RQ2) channel enable 0 hands all four channel pins to port function
// (RQ3) full bridge: direction bits pick pwm legs, other legs output 0
// (RQ4) half bridge: same pwm legs, the other two pins return to port
// (RQ5) software clears latch and direction of idle pins in full bridge
// (RQ6) analog/digital config accepts single-bit and full 8-bit writes; the code stores only the low 4 bits, bits 7..4 read 0
// (RQ7) value k makes lowest k analog pins digital; 8 makes all digital
// (RQ8) software sets converter channel pins to input direction
// (RQ9) software never selects a digital pin as converter channel
// (RQ10) writing analog/digital config inserts one cpu wait cycle
// (RQ11) software avoids that write while peripheral clock is stopped
// (RQ12) input switch bits reassign certain alternate inputs to other pins
// (RQ13) pin routing follows register fields, changing on the next clock
`timescale 1ns/100ps
module motor_and_analog_pin_select
  import pin_select_pkg::*;
#(
  parameter int N_CH     = pin_select_pkg::NUM_MOTOR_CH,
  parameter int N_ANALOG = pin_select_pkg::NUM_ANALOG_PINS,
  parameter int N_SWITCH = pin_select_pkg::NUM_SWITCH
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  bus_req,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_bit_op,
  input  wire logic [2:0]            bus_bit_idx,
  input  wire logic [15:0]           bus_addr,
  input  wire logic [7:0]            bus_wdata,
  output logic      [7:0]            bus_rdata,
  output logic                       bus_ack,
  output logic                       bus_wait,
  input  wire logic [2*N_CH-1:0]     motor_direction_bits,
  input  wire logic [N_CH-1:0]       pwm_in,
  input  wire logic [4*N_CH-1:0]     port_output_latch,
  output logic      [4*N_CH-1:0]     motor_driver_output,
  output logic      [4*N_CH-1:0]     motor_pin_owned,
  output logic      [N_ANALOG-1:0]   analog_pin_digital,
  input  wire logic [N_SWITCH-1:0]   main_pin_in,
  input  wire logic [N_SWITCH-1:0]   alt_pin_in,
  output logic      [N_SWITCH-1:0]   switched_func_in
);
  import pin_select_pkg::*;

  logic [7:0]          motor_port_mode_control;
  logic [7:0]          analog_digital_pin_config;
  logic [7:0]          input_switch_control;
  bus_state_e          state;
  bus_state_e          next_state;
  logic [N_SWITCH-1:0] main_meta;
  logic [N_SWITCH-1:0] main_sync;
  logic [N_SWITCH-1:0] alt_meta;
  logic [N_SWITCH-1:0] alt_sync;

  // bus decode
  wire hit_analog = bus_addr == ANALOG_CFG_ADDR;
  wire hit_motor  = bus_addr == MOTOR_MODE_ADDR;
  wire hit_switch = bus_addr == IN_SWITCH_ADDR;
  wire analog_wr  = bus_req & bus_wr & hit_analog;
  wire do_access  = ((state == BUS_IDLE) & bus_req & ~analog_wr) | (state == BUS_STALL);
  wire do_write   = do_access & bus_wr;

  // (RQ6) single-bit merge or whole byte
  function automatic logic [7:0] merge(
    input logic [7:0] cur,
    input logic       bit_op,
    input logic [2:0] idx,
    input logic [7:0] data
  );
    logic [7:0] res;
    res = cur;
    if (bit_op)
      res[idx] = data[0];
    else
      res = data;
    return res;
  endfunction

  wire [7:0] next_motor_mode = merge(motor_port_mode_control, bus_bit_op, bus_bit_idx,
                                     bus_wdata);
  wire [7:0] next_switch_ctl = merge(input_switch_control, bus_bit_op, bus_bit_idx,
                                     bus_wdata);
  wire [7:0] analog_tmp      = merge(analog_digital_pin_config, bus_bit_op, bus_bit_idx,
                                     bus_wdata);
  wire [7:0] next_analog_cfg = {4'h0, analog_tmp[ANALOG_CFG_W-1:0]};

  wire [7:0] read_mux = hit_analog ? analog_digital_pin_config :
                        hit_motor  ? motor_port_mode_control :
                        hit_switch ? input_switch_control : 8'h00;

  // (RQ10) analog config write stalls one cycle
  always_comb
  begin
    next_state = state;
    case (state)
      BUS_IDLE:
      begin
        if (analog_wr)
          next_state = BUS_STALL;
        else if (bus_req)
          next_state = BUS_DONE;
      end
      BUS_STALL: next_state = BUS_DONE;
      BUS_DONE:  next_state = BUS_IDLE;
      default:   next_state = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state    <= BUS_IDLE;
      bus_ack  <= 1'b0;
      bus_wait <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      bus_ack  <= next_state == BUS_DONE;
      bus_wait <= next_state == BUS_STALL;
    end
  end

  // (RQ1) registers cleared by reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      motor_port_mode_control   <= REG_RESET;
      analog_digital_pin_config <= REG_RESET;
      input_switch_control      <= REG_RESET;
      bus_rdata                 <= REG_RESET;
    end
    else
    begin
      if (do_write & hit_motor)
        motor_port_mode_control <= next_motor_mode;
      if (do_write & hit_analog)
        analog_digital_pin_config <= next_analog_cfg;
      if (do_write & hit_switch)
        input_switch_control <= next_switch_ctl;
      if (do_access & ~bus_wr)
        bus_rdata <= read_mux;
    end
  end

  // motor channel routing
  logic [4*N_CH-1:0] next_out;
  logic [4*N_CH-1:0] next_owned;

  genvar ch;
  generate
    for (ch = 0; ch < N_CH; ch++)
    begin : g_ch
      motor_channel_mux u_mux (
        .motor_channel_enable (motor_port_mode_control[MOTOR_EN_LSB + ch]),
        .bridge_type_select   (motor_port_mode_control[BRIDGE_SEL_LSB + ch]),
        .motor_direction_bits (motor_direction_bits[2*ch +: 2]),
        .pwm                  (pwm_in[ch]),
        .port_output_latch    (port_output_latch[4*ch +: 4]),
        .pin_value            (next_out[4*ch +: 4]),
        .pin_owned            (next_owned[4*ch +: 4])
      );
    end
  endgenerate

  // (RQ7) lowest k pins digital
  logic [N_ANALOG-1:0] next_digital;
  genvar p;
  generate
    for (p = 0; p < N_ANALOG; p++)
    begin : g_an
      assign next_digital[p] =
        32'(analog_digital_pin_config[ANALOG_CFG_W-1:0]) > p;
    end
  endgenerate

  // (RQ12) input switch selection
  wire [N_SWITCH-1:0] next_switched = (input_switch_control[N_SWITCH-1:0] & alt_sync)
                                    | (~input_switch_control[N_SWITCH-1:0] & main_sync);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      main_meta <= '0;
      main_sync <= '0;
      alt_meta  <= '0;
      alt_sync  <= '0;
    end
    else
    begin
      main_meta <= main_pin_in;
      main_sync <= main_meta;
      alt_meta  <= alt_pin_in;
      alt_sync  <= alt_meta;
    end
  end

  // (RQ13) registered pin routing
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      motor_driver_output <= '0;
      motor_pin_owned     <= '0;
      analog_pin_digital  <= '0;
      switched_func_in    <= '0;
    end
    else
    begin
      motor_driver_output <= next_out;
      motor_pin_owned     <= next_owned;
      analog_pin_digital  <= next_digital;
      switched_func_in    <= next_switched;
    end
  end

  // checks
  sequence s_analog_write;
    (state == BUS_IDLE) && bus_req && bus_wr && hit_analog;
  endsequence

  sequence s_stall_then_ack;
    bus_wait && !bus_ack ##1 bus_ack && !bus_wait;
  endsequence

  a_reset_clear: assert property (@(posedge clk_sys) // RQ1
    $fell(rst) |-> motor_port_mode_control == 8'h00 && analog_digital_pin_config == 8'h00)
    else $error("registers not clear after reset");

  a_port_mode: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
    !motor_port_mode_control[MOTOR_EN_LSB] |=> motor_pin_owned[3:0] == 4'h0)
    else $error("disabled channel still owns pins");

  a_full_bridge: assert property (@(posedge clk_sys) disable iff (rst) // RQ3
    motor_port_mode_control[MOTOR_EN_LSB] && !motor_port_mode_control[BRIDGE_SEL_LSB]
    && motor_direction_bits[1:0] == 2'b10
    |=> motor_pin_owned[3:0] == 4'hf && motor_driver_output[0] == 1'b0
    && motor_driver_output[2] == 1'b0 && motor_driver_output[3] == $past(pwm_in[0]))
    else $error("full bridge legs wrong");

  a_half_bridge: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
    motor_port_mode_control[MOTOR_EN_LSB] && motor_port_mode_control[BRIDGE_SEL_LSB]
    && motor_direction_bits[1:0] == 2'b01
    |=> motor_pin_owned[3:0] == 4'b1001
    && motor_driver_output[1] == $past(port_output_latch[1]))
    else $error("half bridge routing wrong");

  a_bit_write: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
    do_write && hit_analog && bus_bit_op && bus_bit_idx < 3'd4
    |=> analog_digital_pin_config[$past(bus_bit_idx)] == $past(bus_wdata[0]))
    else $error("single bit write lost");

  a_digital_count: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
    analog_digital_pin_config[3:0] <= ANALOG_ALL_DIGITAL
    |=> $countones(analog_pin_digital) == $past(analog_digital_pin_config[3:0])
    && (analog_pin_digital == 8'h00 || analog_pin_digital[0]))
    else $error("digital pin count wrong");

  a_analog_wait: assert property (@(posedge clk_sys) disable iff (rst) // RQ10
    s_analog_write |=> s_stall_then_ack)
    else $error("analog config write without wait cycle");

  a_other_nowait: assert property (@(posedge clk_sys) disable iff (rst) // RQ10
    (state == BUS_IDLE) && bus_req && !hit_analog |=> bus_ack && !bus_wait)
    else $error("unexpected wait or missing ack");

  a_switch_pick: assert property (@(posedge clk_sys) disable iff (rst) // RQ12
    input_switch_control[0] |=> switched_func_in[0] == $past(alt_sync[0]))
    else $error("switched input not taken from alternate pin");

  a_route_next: assert property (@(posedge clk_sys) disable iff (rst) // RQ13
    do_write && hit_motor && !bus_bit_op && bus_wdata == 8'h00 |=> ##1 motor_pin_owned == '0)
    else $error("routing did not follow register write");

endmodule

/* motor_compare_model.sv */
`timescale 1ns/100ps
module motor_compare_model
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] dir_cfg,
  output logic      [7:0] motor_direction_bits,
  output logic      [3:0] pwm_in
);
  logic [3:0] phase;
  // direction bits and pwm levels change only after the rising edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      phase                <= 4'h0;
      pwm_in               <= 4'h0;
      motor_direction_bits <= 8'h00;
    end
    else
    begin
      phase                <= phase + 4'h1;
      pwm_in               <= phase ^ {phase[0], phase[3:1]};
      motor_direction_bits <= dir_cfg;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/100ps
module tb;
  import pin_select_pkg::*;
  logic clk_sys, rst, bus_req, bus_wr, bus_bit_op, bus_ack, bus_wait;
  logic [2:0]  bus_bit_idx;
  logic [15:0] bus_addr, port_output_latch, motor_driver_output, motor_pin_owned;
  logic [7:0]  bus_wdata, bus_rdata, dir_cfg, motor_direction_bits, analog_pin_digital;
  logic [7:0]  main_pin_in, alt_pin_in, switched_func_in, q;
  logic [3:0]  pwm_in, pm, own, p;
  logic        st;
  int          fail_count, comparisons, cyc;
  motor_and_analog_pin_select i_dut (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .bus_req              (bus_req),
    .bus_wr               (bus_wr),
    .bus_bit_op           (bus_bit_op),
    .bus_bit_idx          (bus_bit_idx),
    .bus_addr             (bus_addr),
    .bus_wdata            (bus_wdata),
    .bus_rdata            (bus_rdata),
    .bus_ack              (bus_ack),
    .bus_wait             (bus_wait),
    .motor_direction_bits (motor_direction_bits),
    .pwm_in               (pwm_in),
    .port_output_latch    (port_output_latch),
    .motor_driver_output  (motor_driver_output),
    .motor_pin_owned      (motor_pin_owned),
    .analog_pin_digital   (analog_pin_digital),
    .main_pin_in          (main_pin_in),
    .alt_pin_in           (alt_pin_in),
    .switched_func_in     (switched_func_in)
  );
  motor_compare_model i_far (.clk_sys(clk_sys), .rst(rst), .dir_cfg(dir_cfg),
    .motor_direction_bits(motor_direction_bits), .pwm_in(pwm_in));
  initial
  begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, b, input logic [2:0] i, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge clk_sys);
    {bus_req, bus_wr, bus_bit_op, bus_bit_idx, bus_addr, bus_wdata} = {1'b1, w, b, i, a, d};
    cyc = 0;
    st = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      cyc++;
      if (bus_wait === 1'b1)
        st = 1;
    end while (bus_ack !== 1'b1 && cyc < 8);
    q = bus_rdata;
    if (bus_ack !== 1'b1)
    begin
      fail_count++;
      $display("unexpected bus_ack expected 1 seen %b", bus_ack);
      end_sim();
    end
    @(negedge clk_sys);
    bus_req = 0;
  endtask
  task automatic reset_values();
    bus(0, 0, 0, ANALOG_CFG_ADDR, 8'h00);
    chk("analog cfg reset", 16'h0000, q);
    bus(0, 0, 0, MOTOR_MODE_ADDR, 8'h00);
    chk("motor mode reset", 16'h0000, q);
    chk("pins reset", 16'h0000, {analog_pin_digital, motor_pin_owned[7:0]});
    bus(0, 0, 0, 16'hff00, 8'h5a);
    chk("unmapped read", 16'h0000, q);
  endtask
  task automatic motor_modes(input logic [7:0] mode, input logic [7:0] dir,
                             input logic [15:0] lat);
    logic [15:0] ev, eo;
    port_output_latch = lat;
    dir_cfg = dir;
    bus(1, 0, 0, MOTOR_MODE_ADDR, mode);
    for (int k = 0; k < 3; k++)
    begin
      p = pwm_in;
      @(posedge clk_sys);
      @(negedge clk_sys);
      for (int ch = 0; ch < 4; ch++)
      begin
        pm = (dir_cfg[2*ch+1] ? 4'h2 : 4'h1) | (^dir_cfg[2*ch+:2] ? 4'h8 : 4'h4);
        own = !mode[ch] ? 4'h0 : mode[4+ch] ? pm : 4'hf;
        eo[4*ch+:4] = own;
        ev[4*ch+:4] = (pm & {4{p[ch]}} & own) | (~own & lat[4*ch+:4]);
      end
      chk("pin owned", eo, motor_pin_owned);
      chk("pin value", ev, motor_driver_output);
    end
  endtask
  task automatic analog_config();
    for (int k = 0; k <= 8; k++)
    begin
      bus(1, 0, 0, ANALOG_CFG_ADDR, 8'(k));
      chk("analog cfg stall", 16'h0102, {7'h00, st, 8'(cyc)});
      @(posedge clk_sys);
      #1;
      chk("digital pins", 16'((1 << k) - 1), analog_pin_digital);
    end
    bus(1, 0, 0, ANALOG_CFG_ADDR, 8'h00);
    bus(1, 1, 3'h3, ANALOG_CFG_ADDR, 8'h01);
    bus(0, 0, 0, ANALOG_CFG_ADDR, 8'h00);
    chk("analog cfg bit write", 16'h0008, q);
    chk("digital after bit", 16'h00ff, analog_pin_digital);
  endtask
  task automatic input_switch();
    main_pin_in = 8'h55;
    alt_pin_in = 8'hf0;
    bus(1, 0, 0, IN_SWITCH_ADDR, 8'h0f);
    repeat (4) @(negedge clk_sys);
    chk("switched inputs", 16'h0050, switched_func_in);
    bus(0, 0, 0, IN_SWITCH_ADDR, 8'h00);
    chk("switch control", 16'h000f, q);
  endtask
  initial
  begin
    {rst, bus_req, bus_wr, bus_bit_op, bus_bit_idx, bus_addr, bus_wdata} = '0;
    {port_output_latch, dir_cfg, main_pin_in, alt_pin_in} = '0;
    fail_count = 0;
    comparisons = 0;
    rst = 1;
    repeat (5) @(negedge clk_sys);
    rst = 0;
    reset_values();
    // idle legs held at zero latch in full bridge
    motor_modes(8'h0e, 8'he4, 16'h0000);
    motor_modes(8'hff, 8'he1, 16'ha5c3);
    motor_modes(8'h9f, 8'he4, 16'h300a);
    motor_modes(8'h6f, 8'h4e, 16'h0000);
    motor_modes(8'h00, 8'h4e, 16'h1234);
    analog_config();
    input_switch();
    end_sim();
  end
endmodule
